/* File: hw/segment_address_extension_unit.sv */
// Segment and page registers with code segment save/restore control
// Function
// RULE1 - Vector and service code fetch use interrupt segment as upper address bits.
// RULE2 - Interrupt segment register readable, writable; upper two bits reserved, kept zero.
// RULE3 - DMA segment register readable, writable; six low bits only, upper reserved.
// RULE4 - DMA with segment-select set uses DMA segment register for upper bits.
// RULE5 - DMA with segment-select clear uses interrupt segment register instead.
// RULE6 - Far jump, call, return load code segment directly or from stack.
// RULE7 - Software writes code segment only in service routine with save disabled.
// RULE8 - Remap flag swaps page register locations with port 0-3 data registers.
// RULE9 - Save disabled: service routine fetches from interrupt segment, no segment push.
// RULE10 - Save disabled: far calls in service still update unused code segment.
// RULE11 - Save enabled: push old code segment, then load it from interrupt segment.
// RULE12 - Save enabled: interrupt return restores code segment from stack.
// RULE13 - Data page translation identical in service routines and main code.
// RULE14 - Data access: top two address bits pick page register, join fourteen bits.
// RULE15 - Fetch address is code segment above the sixteen-bit virtual address.
// RULE16 - Address multiplexer selects upper bits by data, fetch or DMA access.
`timescale 1ns/1ps
`include "segment_ext_defines.svh"
module segment_address_extension_unit (
    // Clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_b_in,
    // Register file access
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    input  wire segment_ext_pkg::page_t      reg_page_in,
    input  wire logic [7:0]                  reg_addr_in,
    input  wire logic [7:0]                  reg_wdata_in,
    output logic [7:0]                       reg_rdata_out,
    output logic                             reg_hit_out,
    output logic                             port_data_sel_out,
    // Memory access request
    input  wire logic                        acc_valid_in,
    input  wire segment_ext_pkg::acc_kind_e  acc_kind_in,
    input  wire logic [15:0]                 vaddr_in,
    input  wire logic                        vector_fetch_in,
    input  wire logic                        in_service_in,
    input  wire logic                        dma_segment_select_in,
    output segment_ext_pkg::paddr_t          paddr_out,
    output logic                             paddr_valid_out,
    // Code segment events
    input  wire logic                        far_load_in,
    input  wire segment_ext_pkg::seg_t       far_seg_in,
    input  wire logic                        far_ret_in,
    input  wire logic                        irq_entry_in,
    input  wire logic                        iret_in,
    input  wire segment_ext_pkg::seg_t       stack_seg_in,
    output logic                             push_seg_valid_out,
    output segment_ext_pkg::seg_t            push_seg_out,
    output logic                             segment_save_enable_out,
    output logic                             page_reg_remap_out
);
    import segment_ext_pkg::*;

    seg_t   code_segment_reg_q;
    seg_t   interrupt_segment_reg_q;
    seg_t   dma_segment_reg_q;
    page_t  data_page_regs_q [4];
    logic   save_en_q;
    logic   remap_q;
    logic   in_page;
    logic   page_hit;
    logic [1:0] page_idx;
    logic   hit_code;
    logic   hit_mode;
    logic   hit_int;
    logic   hit_dma;
    logic [7:0] rdata_d;

    seg_bus_if bus ();

    assign in_page  = (reg_page_in == `SEG_REG_PAGE);
    assign page_idx = reg_addr_in[1:0];
    assign hit_code = in_page && (reg_addr_in == `SEG_CODE_SEG_OFF);
    assign hit_mode = in_page && (reg_addr_in == `SEG_EXT_MODE_OFF);
    assign hit_int  = in_page && (reg_addr_in == `SEG_INT_SEG_OFF);
    assign hit_dma  = in_page && (reg_addr_in == `SEG_DMA_SEG_OFF);

    // Page regs sit in group E for any page once remapped; ports take their page 21 slots
    always_comb begin
        if (remap_q) begin
            page_hit          = (reg_addr_in[7:2] == 6'(`SEG_PAGE_REMAP_BASE >> 2)); // RULE8
            port_data_sel_out = in_page && (reg_addr_in[7:2] == 6'(`SEG_PAGE_BASE >> 2)); // RULE8
        end else begin
            page_hit          = in_page && (reg_addr_in[7:2] == 6'(`SEG_PAGE_BASE >> 2));
            port_data_sel_out = (reg_addr_in[7:2] == 6'(`SEG_PAGE_REMAP_BASE >> 2));
        end
    end

    assign reg_hit_out = page_hit || hit_code || hit_mode || hit_int || hit_dma;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            interrupt_segment_reg_q <= `SEG_INT_SEG_RST;
            dma_segment_reg_q       <= `SEG_DMA_SEG_RST;
        end else if (reg_wr_in) begin
            // Reserved upper bits are dropped so they always read back zero
            if (hit_int) begin
                interrupt_segment_reg_q <= reg_wdata_in[5:0]; // RULE2
            end
            if (hit_dma) begin
                dma_segment_reg_q <= reg_wdata_in[5:0]; // RULE3
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            save_en_q <= `SEG_SAVE_EN_RST;
            remap_q   <= `SEG_REMAP_RST;
        end else if (reg_wr_in && hit_mode) begin
            save_en_q <= reg_wdata_in[`SEG_SAVE_EN_BIT];
            remap_q   <= reg_wdata_in[`SEG_REMAP_BIT]; // RULE8
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 4; i++) begin
                data_page_regs_q[i] <= `SEG_PAGE_RST;
            end
        end else if (reg_wr_in && page_hit) begin
            data_page_regs_q[page_idx] <= reg_wdata_in;
        end
    end

    // Hardware events win over a software write in the same cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            code_segment_reg_q <= `SEG_CODE_SEG_RST;
        end else if (irq_entry_in && save_en_q) begin
            code_segment_reg_q <= interrupt_segment_reg_q; // RULE11
        end else if (iret_in && save_en_q) begin
            code_segment_reg_q <= stack_seg_in; // RULE12
        end else if (far_ret_in) begin
            code_segment_reg_q <= stack_seg_in; // RULE6
        end else if (far_load_in) begin
            code_segment_reg_q <= far_seg_in; // RULE6 RULE10
        end else if (reg_wr_in && hit_code) begin
            // Unsynchronised with fetch; safe only while the register is not in use
            code_segment_reg_q <= reg_wdata_in[5:0]; // RULE7
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            push_seg_valid_out <= 1'b0;
            push_seg_out       <= '0;
        end else begin
            push_seg_valid_out <= irq_entry_in && save_en_q; // RULE11 RULE9
            if (irq_entry_in) begin
                push_seg_out <= code_segment_reg_q; // RULE11
            end
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (page_hit) begin
            rdata_d = data_page_regs_q[page_idx];
        end else if (hit_code) begin
            rdata_d = {2'h0, code_segment_reg_q};
        end else if (hit_mode) begin
            rdata_d[`SEG_SAVE_EN_BIT] = save_en_q;
            rdata_d[`SEG_REMAP_BIT]   = remap_q;
        end else if (hit_int) begin
            rdata_d = {2'h0, interrupt_segment_reg_q}; // RULE2
        end else if (hit_dma) begin
            rdata_d = {2'h0, dma_segment_reg_q}; // RULE3
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
        end
    end

    assign bus.code_seg    = code_segment_reg_q;
    assign bus.int_seg     = interrupt_segment_reg_q;
    assign bus.dma_seg     = dma_segment_reg_q;
    assign bus.pages       = data_page_regs_q;
    assign bus.req         = acc_valid_in;
    assign bus.kind        = acc_kind_in;
    assign bus.vaddr       = vaddr_in;
    assign bus.dma_sel     = dma_segment_select_in;
    assign bus.use_int_seg = vector_fetch_in || (in_service_in && !save_en_q); // RULE1 RULE9 RULE11

    paddr_former u_former (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .bus      (bus)
    );

    assign paddr_out               = bus.paddr;
    assign paddr_valid_out         = bus.paddr_valid;
    assign segment_save_enable_out = save_en_q;
    assign page_reg_remap_out      = remap_q;

    page_t        page_sel;
    logic [13:0]  va_low;
    assign page_sel = data_page_regs_q[vaddr_in[15:14]];
    assign va_low  = vaddr_in[13:0];

    AST_FETCH_CODE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE15
        acc_valid_in && acc_kind_in == ACC_FETCH && !vector_fetch_in && !in_service_in
        |=> paddr_valid_out && paddr_out == {$past(code_segment_reg_q), $past(vaddr_in)})
        else $error("fetch did not use code segment");
    AST_VECTOR_INT: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE1
        acc_valid_in && acc_kind_in == ACC_FETCH && vector_fetch_in
        |=> paddr_out[21:16] == $past(interrupt_segment_reg_q))
        else $error("vector fetch did not use interrupt segment");
    AST_SERVICE_NOSAVE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
        acc_valid_in && acc_kind_in == ACC_FETCH && in_service_in && !save_en_q
        |=> paddr_out[21:16] == $past(interrupt_segment_reg_q))
        else $error("service fetch without save did not use interrupt segment");
    AST_DMA_SEG: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE4
        acc_valid_in && acc_kind_in == ACC_DMA && dma_segment_select_in
        |=> paddr_out == {$past(dma_segment_reg_q), $past(vaddr_in)})
        else $error("dma did not use dma segment");
    AST_DMA_INT: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE5
        acc_valid_in && acc_kind_in == ACC_DMA && !dma_segment_select_in
        |=> paddr_out[21:16] == $past(interrupt_segment_reg_q))
        else $error("dma did not fall back to interrupt segment");
    AST_DATA_PAGE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE14
        acc_valid_in && acc_kind_in == ACC_DATA
        |=> paddr_out == {$past(page_sel), $past(va_low)})
        else $error("data page translation wrong");
    AST_IRQ_SAVE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE11
        irq_entry_in && save_en_q
        |=> push_seg_valid_out && push_seg_out == $past(code_segment_reg_q)
            && code_segment_reg_q == $past(interrupt_segment_reg_q))
        else $error("interrupt entry did not save and load code segment");
    AST_IRQ_NOSAVE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
        irq_entry_in && !save_en_q && !far_load_in && !far_ret_in && !(reg_wr_in && hit_code)
        |=> !push_seg_valid_out && $stable(code_segment_reg_q))
        else $error("interrupt entry without save touched code segment");
    AST_IRET_RESTORE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE12
        iret_in && save_en_q && !irq_entry_in |=> code_segment_reg_q == $past(stack_seg_in))
        else $error("interrupt return did not restore code segment");
    AST_FAR_LOAD: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE6
        far_load_in && !far_ret_in && !irq_entry_in && !iret_in |=> code_segment_reg_q == $past(far_seg_in))
        else $error("far transfer did not load code segment");
    AST_INT_SEG_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
        reg_rd_in && hit_int |=> reg_rdata_out == {2'h0, $past(interrupt_segment_reg_q)})
        else $error("interrupt segment readback wrong");
endmodule // segment_address_extension_unit

/* File: hw/segment_ext_defines.svh */
// Offsets, field positions and reset values of the segment address extension unit
`ifndef SEGMENT_EXT_DEFINES_SVH
`define SEGMENT_EXT_DEFINES_SVH

`define SEG_REG_PAGE        8'h15
`define SEG_PAGE_BASE       8'hF0
`define SEG_PAGE_REMAP_BASE 8'hE0
`define SEG_CODE_SEG_OFF    8'hF4
`define SEG_EXT_MODE_OFF    8'hF6
`define SEG_INT_SEG_OFF     8'hF8
`define SEG_DMA_SEG_OFF     8'hF9

`define SEG_REMAP_BIT       5
`define SEG_SAVE_EN_BIT     6

`define SEG_CODE_SEG_RST    6'h00
`define SEG_INT_SEG_RST     6'h00
`define SEG_DMA_SEG_RST     6'h00
`define SEG_PAGE_RST        8'h00
`define SEG_REMAP_RST       1'b0
`define SEG_SAVE_EN_RST     1'b0

`endif

/* File: hw/segment_ext_pkg.sv */
// Types shared by the segment address extension unit
package segment_ext_pkg;
    typedef logic [5:0]  seg_t;
    typedef logic [7:0]  page_t;
    typedef logic [21:0] paddr_t;
    typedef enum logic [1:0] {
        ACC_DATA,
        ACC_FETCH,
        ACC_DMA
    } acc_kind_e;
endpackage

/* File: hw/seg_bus_if.sv */
// Carrier between the segment register file and the physical address former
`timescale 1ns/1ps
interface seg_bus_if;
    import segment_ext_pkg::*;
    seg_t       code_seg;
    seg_t       int_seg;
    seg_t       dma_seg;
    page_t      pages [4];
    logic       req;
    acc_kind_e  kind;
    logic [15:0] vaddr;
    logic       dma_sel;
    logic       use_int_seg;
    paddr_t     paddr;
    logic       paddr_valid;

    modport src (output code_seg, int_seg, dma_seg, pages, req, kind, vaddr, dma_sel, use_int_seg,
                 input paddr, paddr_valid);
    modport mux (input code_seg, int_seg, dma_seg, pages, req, kind, vaddr, dma_sel, use_int_seg,
                 output paddr, paddr_valid);
endinterface

/* File: hw/paddr_former.sv */
// Physical address multiplexer: picks the upper address source by access type
`timescale 1ns/1ps
`include "segment_ext_defines.svh"
module paddr_former (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // Segment state and request
    seg_bus_if.mux    bus
);
    import segment_ext_pkg::*;

    paddr_t paddr_d;

    always_comb begin
        paddr_d = '0;
        case (bus.kind)
            ACC_DATA: begin
                // Page regs are used the same way inside and outside service routines
                paddr_d = {bus.pages[bus.vaddr[15:14]], bus.vaddr[13:0]}; // RULE14 RULE13 RULE16
            end
            ACC_FETCH: begin
                if (bus.use_int_seg) begin
                    paddr_d = {bus.int_seg, bus.vaddr}; // RULE1 RULE9 RULE16
                end else begin
                    paddr_d = {bus.code_seg, bus.vaddr}; // RULE15 RULE16
                end
            end
            ACC_DMA: begin
                if (bus.dma_sel) begin
                    paddr_d = {bus.dma_seg, bus.vaddr}; // RULE4 RULE16
                end else begin
                    paddr_d = {bus.int_seg, bus.vaddr}; // RULE5 RULE16
                end
            end
            default: begin
                paddr_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus.paddr       <= '0;
            bus.paddr_valid <= 1'b0;
        end else begin
            bus.paddr_valid <= bus.req;
            if (bus.req) begin
                bus.paddr <= paddr_d;
            end
        end
    end
endmodule // paddr_former

/* File: test/core_dma_model.sv */
// Behavioural model of the CPU core and DMA controller issuing accesses and segment events
`timescale 1ns/1ps
module core_dma_model (
    // Clock
    input  wire logic                       clk_in,
    // Memory access request
    output logic                            acc_valid_out,
    output segment_ext_pkg::acc_kind_e      acc_kind_out,
    output logic [15:0]                     vaddr_out,
    output logic                            vector_fetch_out,
    output logic                            in_service_out,
    output logic                            dma_sel_out,
    // Code segment events
    output logic                            far_load_out,
    output segment_ext_pkg::seg_t           far_seg_out,
    output logic                            far_ret_out,
    output logic                            irq_entry_out,
    output logic                            iret_out,
    output segment_ext_pkg::seg_t           stack_seg_out
);
    import segment_ext_pkg::*;

    initial begin
        {acc_valid_out, vector_fetch_out, in_service_out, dma_sel_out} = 4'h0;
        {far_load_out, far_ret_out, irq_entry_out, iret_out} = 4'h0;
        acc_kind_out = ACC_DATA;
        vaddr_out = 16'h0000;
        far_seg_out = 6'h00;
        stack_seg_out = 6'h00;
    end

    // One access; service and select stay as levels afterwards
    task automatic access(input acc_kind_e kind, input logic [15:0] va, input logic vf, svc, sel);
        @(negedge clk_in);
        acc_kind_out = kind;
        vaddr_out = va;
        vector_fetch_out = vf;
        in_service_out = svc;
        dma_sel_out = sel;
        acc_valid_out = 1'b1;
        @(negedge clk_in);
        acc_valid_out = 1'b0;
        // Released address must not keep looking valid
        vaddr_out = ~va;
    endtask

    // Pulse order: {irq_entry, iret, far_ret, far_load}
    task automatic seg_event(input logic [3:0] which, input seg_t seg);
        @(negedge clk_in);
        {irq_entry_out, iret_out, far_ret_out, far_load_out} = which;
        far_seg_out = seg;
        stack_seg_out = seg;
        @(negedge clk_in);
        {irq_entry_out, iret_out, far_ret_out, far_load_out} = 4'h0;
        far_seg_out = ~seg;
        stack_seg_out = ~seg;
    endtask
endmodule // core_dma_model

/* File: test/test_segment_address_extension_unit.sv */
// Self-checking testbench of the segment address extension unit
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module test_segment_address_extension_unit;
    import segment_ext_pkg::*;

    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    page_t       reg_page_in = 8'h00;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic [7:0]  reg_rdata_out;
    logic        reg_hit_out, port_data_sel_out, paddr_valid_out, push_seg_valid_out;
    paddr_t      paddr_out;
    seg_t        push_seg_out, far_seg, stack_seg;
    logic        save_en, remap, acc_valid, vfetch, in_svc, dma_sel, far_load, far_ret, irq_entry, iret;
    acc_kind_e   acc_kind;
    logic [15:0] vaddr;
    logic [7:0]  rd;
    int          num_errors = 0;
    int          check_count = 0;
    logic [7:0]  pg [4] = '{8'h11, 8'h22, 8'h93, 8'hC4};
    logic [7:0]  rst_addr [8] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'hF8, 8'hF9};

    always #4 clk_in = ~clk_in;

    segment_address_extension_unit dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_page_in(reg_page_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out), .port_data_sel_out(port_data_sel_out),
        .acc_valid_in(acc_valid), .acc_kind_in(acc_kind), .vaddr_in(vaddr), .vector_fetch_in(vfetch),
        .in_service_in(in_svc), .dma_segment_select_in(dma_sel), .paddr_out(paddr_out),
        .paddr_valid_out(paddr_valid_out), .far_load_in(far_load), .far_seg_in(far_seg),
        .far_ret_in(far_ret), .irq_entry_in(irq_entry), .iret_in(iret), .stack_seg_in(stack_seg),
        .push_seg_valid_out(push_seg_valid_out), .push_seg_out(push_seg_out),
        .segment_save_enable_out(save_en), .page_reg_remap_out(remap));

    core_dma_model core (
        .clk_in(clk_in), .acc_valid_out(acc_valid), .acc_kind_out(acc_kind), .vaddr_out(vaddr),
        .vector_fetch_out(vfetch), .in_service_out(in_svc), .dma_sel_out(dma_sel),
        .far_load_out(far_load), .far_seg_out(far_seg), .far_ret_out(far_ret),
        .irq_entry_out(irq_entry), .iret_out(iret), .stack_seg_out(stack_seg));

    task automatic reg_write(input page_t page, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        {reg_page_in, reg_addr_in, reg_wdata_in, reg_wr_in} = {page, addr, data, 1'b1};
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        // Released data bus shows a changed value
        reg_wdata_in = ~data;
    endtask

    task automatic reg_read(input page_t page, input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_in);
        {reg_page_in, reg_addr_in, reg_rd_in} = {page, addr, 1'b1};
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        data = reg_rdata_out;
    endtask

    task automatic acc(input acc_kind_e k, input logic [15:0] va, input logic vf, svc, sel, input paddr_t exp);
        core.access(k, va, vf, svc, sel);
        `CHECK_EQ(paddr_valid_out, 1'b1)
        `CHECK_EQ(paddr_out, exp)
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run is under 150 cycles; far margin before declaring a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (20) @(negedge clk_in);
        rst_b_in = 1'b1;
        foreach (rst_addr[i]) begin
            reg_read(8'h15, rst_addr[i], rd);
            `CHECK_EQ(rd, 8'h00)
            `CHECK_EQ(reg_hit_out, 1'b1)
        end
        $display("test reset_values done");
        reg_write(8'h15, 8'hF8, 8'h3F);
        reg_read(8'h15, 8'hF8, rd);
        `CHECK_EQ(rd, 8'h3F)
        reg_write(8'h15, 8'hF9, 8'h2A);
        reg_read(8'h15, 8'hF9, rd);
        `CHECK_EQ(rd, 8'h2A)
        reg_read(8'h15, 8'hFA, rd);
        `CHECK_EQ(rd, 8'h00)
        `CHECK_EQ(reg_hit_out, 1'b0)
        $display("test segment_regs done");
        for (int i = 0; i < 4; i++) begin
            reg_write(8'h15, 8'hF0 + 8'(i), pg[i]);
            acc(ACC_DATA, {2'(i), 14'h2ABC}, 1'b0, 1'b0, 1'b0, {pg[i], 14'h2ABC});
            acc(ACC_DATA, {2'(i), 14'h0005}, 1'b0, 1'b1, 1'b0, {pg[i], 14'h0005});
        end
        $display("test data_pages done");
        reg_write(8'h15, 8'hF6, 8'h20);
        `CHECK_EQ(remap, 1'b1)
        reg_read(8'h00, 8'hE2, rd);
        `CHECK_EQ(rd, 8'h93)
        @(negedge clk_in);
        {reg_page_in, reg_addr_in} = {8'h15, 8'hF1};
        #1 `CHECK_EQ(port_data_sel_out, 1'b1)
        `CHECK_EQ(reg_hit_out, 1'b0)
        reg_write(8'h15, 8'hF6, 8'h00);
        `CHECK_EQ(remap, 1'b0)
        {reg_page_in, reg_addr_in} = {8'h00, 8'hE1};
        #1 `CHECK_EQ(port_data_sel_out, 1'b1)
        `CHECK_EQ(reg_hit_out, 1'b0)
        $display("test remap done");
        acc(ACC_FETCH, 16'h1234, 1'b0, 1'b1, 1'b0, 22'h3F1234);
        reg_write(8'h15, 8'hF4, 8'h05);
        acc(ACC_FETCH, 16'h1234, 1'b0, 1'b0, 1'b0, 22'h051234);
        acc(ACC_FETCH, 16'h0040, 1'b1, 1'b0, 1'b0, 22'h3F0040);
        core.seg_event(4'b1000, 6'h00);
        `CHECK_EQ(push_seg_valid_out, 1'b0)
        $display("test fetch done");
        core.seg_event(4'b0001, 6'h0A);
        acc(ACC_FETCH, 16'hFFFF, 1'b0, 1'b0, 1'b0, 22'h0AFFFF);
        core.seg_event(4'b0010, 6'h07);
        acc(ACC_FETCH, 16'h0000, 1'b0, 1'b0, 1'b0, 22'h070000);
        core.seg_event(4'b0001, 6'h0B);
        acc(ACC_FETCH, 16'h0100, 1'b0, 1'b1, 1'b0, 22'h3F0100);
        reg_read(8'h15, 8'hF4, rd);
        `CHECK_EQ(rd, 8'h0B)
        $display("test far_transfers done");
        reg_write(8'h15, 8'hF6, 8'h40);
        `CHECK_EQ(save_en, 1'b1)
        core.seg_event(4'b1000, 6'h00);
        `CHECK_EQ(push_seg_valid_out, 1'b1)
        `CHECK_EQ(push_seg_out, 6'h0B)
        reg_read(8'h15, 8'hF4, rd);
        `CHECK_EQ(rd, 8'h3F)
        core.seg_event(4'b0001, 6'h0C);
        acc(ACC_FETCH, 16'h5678, 1'b0, 1'b1, 1'b0, 22'h0C5678);
        acc(ACC_FETCH, 16'h0008, 1'b1, 1'b1, 1'b0, 22'h3F0008);
        core.seg_event(4'b0100, 6'h0B);
        reg_read(8'h15, 8'hF4, rd);
        `CHECK_EQ(rd, 8'h0B)
        reg_write(8'h15, 8'hF6, 8'h00);
        $display("test save_restore done");
        acc(ACC_DMA, 16'h9ABC, 1'b0, 1'b0, 1'b1, 22'h2A9ABC);
        acc(ACC_DMA, 16'h9ABC, 1'b0, 1'b0, 1'b0, 22'h3F9ABC);
        $display("test dma done");
        conclude();
    end
endmodule // test_segment_address_extension_unit
